//--- rtl/fol_pkg.sv
package fol_pkg;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ALT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WAKE = 8'h0c;
  localparam logic [7:0] ADDR_LEVEL = 8'h10;
  // Control register fields
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_OVRST_BIT = 1;
  localparam int CTRL_DUTY_LSB = 2;
  // Status register fields
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_WDF_BIT = 1;
  localparam int STAT_ACT_BIT = 2;
  localparam int STAT_FSAFE_BIT = 3;
  // Pin functions
  typedef enum logic [1:0] {
    FOL_FN_FAIL = 2'h0,
    FOL_FN_WAKE = 2'h1,
    FOL_FN_LS = 2'h2,
    FOL_FN_HS = 2'h3
  } fol_fn_e;
  // Device modes
  typedef enum logic [1:0] {
    FOL_MD_NORMAL = 2'h0,
    FOL_MD_STOP = 2'h1,
    FOL_MD_SLEEP = 2'h3,
    FOL_MD_FSAFE = 2'h2
  } fol_mode_e;
  // Timebases
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MILLI_HZ = 1250;
  localparam int PWM_HZ = 100;
  localparam int BLINK_HALF_CYC = (CLK_HZ / 2) / BLINK_MILLI_HZ * 1000; // Divide first, no overflow
  localparam int PWM_CYC = CLK_HZ / PWM_HZ;
  localparam int CNT_W = 26;
  localparam logic [1:0] DUTY_RESET = 2'h0;
  localparam int UV_LIMIT = 4;
endpackage : fol_pkg

//--- rtl/fol_timebase.sv
`timescale 1ns/1ps
module fol_timebase #(
  parameter int BLINK_HALF = fol_pkg::BLINK_HALF_CYC,
  parameter int PWM_PERIOD = fol_pkg::PWM_CYC
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_sync_n, // Synchronised reset
  input wire logic clk_en, // Clock enable
  input wire logic restart, // Restart both counters
  input wire logic [1:0] duty_sel, // Duty select
  output logic blink_on, // Blink phase, active first
  output logic dim_on // PWM active phase
);
  logic [fol_pkg::CNT_W-1:0] blink_cnt_reg;
  logic [fol_pkg::CNT_W-1:0] pwm_cnt_reg;
  logic [fol_pkg::CNT_W-1:0] dim_len;

  // Active length: 20, 10, 5, 2.5 percent of the period
  always_comb begin
    case (duty_sel)
      2'h0: dim_len = fol_pkg::CNT_W'(PWM_PERIOD / 5);
      2'h1: dim_len = fol_pkg::CNT_W'(PWM_PERIOD / 10);
      2'h2: dim_len = fol_pkg::CNT_W'(PWM_PERIOD / 20);
      default: dim_len = fol_pkg::CNT_W'(PWM_PERIOD / 40);
    endcase
  end

  // Blink half-period counter, restarted on activation
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      blink_cnt_reg <= '0;
      blink_on <= 1'b1;
    end else if (clk_en) begin
      if (restart) begin
        blink_cnt_reg <= '0;
        blink_on <= 1'b1;
      end else if (blink_cnt_reg == fol_pkg::CNT_W'(BLINK_HALF - 1)) begin
        blink_cnt_reg <= '0;
        blink_on <= ~blink_on;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  // PWM period counter, restarted on activation
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_cnt_reg <= '0;
      dim_on <= 1'b1;
    end else if (clk_en) begin
      if (restart || pwm_cnt_reg == fol_pkg::CNT_W'(PWM_PERIOD - 1)) begin
        pwm_cnt_reg <= '0;
        dim_on <= 1'b1;
      end else begin
        pwm_cnt_reg <= pwm_cnt_reg + 1'b1;
        dim_on <= (pwm_cnt_reg + 1'b1) < dim_len;
      end
    end
  end
endmodule : fol_timebase

//--- rtl/fol_top.sv
`timescale 1ns/1ps
module fol_top #(
  parameter int BLINK_HALF = fol_pkg::BLINK_HALF_CYC, // Blink half period cycles
  parameter int PWM_PERIOD = fol_pkg::PWM_CYC, // PWM period cycles
  parameter logic [1:0] HW_CONFIG = 2'h0 // Hardware configuration 1..4 as 0..3
) (
  input wire logic clk_sys, // 100 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [1:0] dev_mode, // Device mode
  input wire logic watchdog_fault_flag_evt, // Watchdog trigger failure pulse
  input wire logic wd_trig_ok, // Successful watchdog trigger pulse
  input wire logic wd_off_stop, // Watchdog disabled in stop
  input wire logic thermal_shutdown_stage_two, // Thermal stage two level
  input wire logic main_regulator_output_short, // Regulator short to ground
  input wire logic main_regulator_output_ov, // Regulator overvoltage
  input wire logic main_regulator_output_uv_evt, // Undervoltage event pulse
  input wire logic main_regulator_output_uv_ok, // Regulator back in range pulse
  output logic fsafe_req, // Fail-safe entry request, pulse on watchdog activation except in config 2, held high while a condition is present
  output logic fail_static_out_o, // Static output low level
  output logic fail_static_out_oe, // Static output drive enable
  input wire logic alt_pin_two_i, // Second pin level
  output logic alt_pin_two_o, // Second pin output level
  output logic alt_pin_two_oe, // Second pin drive enable
  input wire logic fail_dim_test_pin_i, // Third pin level
  output logic fail_dim_test_pin_o, // Third pin output level
  output logic fail_dim_test_pin_oe // Third pin drive enable
);
  logic rst_s1_reg;
  logic rst_sync_n;
  logic force_reg;
  logic ovrst_reg;
  logic [1:0] duty_reg;
  logic [1:0] fn2_reg;
  logic [1:0] fn3_reg;
  logic [1:0] sw_on_reg;
  logic fail_flag_reg;
  logic wd_fault_reg;
  logic wd_first_reg;
  logic [2:0] uv_cnt_reg;
  logic uv_trip_reg;
  logic [1:0] wake_stat_reg;
  logic [1:0] level_reg;
  logic [1:0] pin_prev_reg;
  logic active_reg;
  logic fail_static_reg;
  logic pin2_drive_reg;
  logic pin3_drive_reg;
  logic pin2_hi_reg;
  logic pin3_hi_reg;
  logic blink_on;
  logic dim_on;
  logic wr_en;
  logic rd_en;
  logic wd_act;
  logic cond_act;
  logic cond_present;
  logic set_fail;
  logic active_next;
  logic [1:0] pin_lvl;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // Returns true when function equals the given pin function
  function automatic logic fn_is(input logic [1:0] fn, input fol_pkg::fol_fn_e want);
    fn_is = (fn == want);
  endfunction : fn_is

  // APB strobes, zero wait states; read data captured in setup so it stands at the access edge
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == fol_pkg::ADDR_CTRL ||
    paddr == fol_pkg::ADDR_ALT || paddr == fol_pkg::ADDR_STATUS ||
    paddr == fol_pkg::ADDR_WAKE || paddr == fol_pkg::ADDR_LEVEL);

  // Control and alternate function registers
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      force_reg <= 1'b0;
      ovrst_reg <= 1'b0;
      duty_reg <= fol_pkg::DUTY_RESET;
      fn2_reg <= fol_pkg::FOL_FN_FAIL;
      fn3_reg <= fol_pkg::FOL_FN_FAIL;
      sw_on_reg <= 2'h0;
    end else if (wr_en) begin
      if (paddr == fol_pkg::ADDR_CTRL) begin
        force_reg <= pwdata[fol_pkg::CTRL_FORCE_BIT];
        ovrst_reg <= pwdata[fol_pkg::CTRL_OVRST_BIT];
        duty_reg <= pwdata[fol_pkg::CTRL_DUTY_LSB +: 2];
      end
      if (paddr == fol_pkg::ADDR_ALT) begin
        fn2_reg <= pwdata[1:0];
        fn3_reg <= pwdata[3:2];
        sw_on_reg <= pwdata[5:4];
      end
    end
  end

  // Watchdog first-failure tracking by configuration
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wd_first_reg <= 1'b0;
    end else if (clk_en) begin
      if (wd_trig_ok) begin
        wd_first_reg <= 1'b0;
      end else if (watchdog_fault_flag_evt) begin
        wd_first_reg <= 1'b1;
      end
    end
  end

  // Config 3/4 need a second failure, 1/2 the first
  assign wd_act = watchdog_fault_flag_evt && (!HW_CONFIG[1] || wd_first_reg);
  // Undervoltage run counter
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      uv_cnt_reg <= 3'h0;
      uv_trip_reg <= 1'b0;
    end else if (clk_en) begin
      if (main_regulator_output_uv_ok) begin
        uv_cnt_reg <= 3'h0;
        uv_trip_reg <= 1'b0;
      end else if (main_regulator_output_uv_evt) begin
        if (uv_cnt_reg == 3'(fol_pkg::UV_LIMIT - 1)) begin
          uv_trip_reg <= 1'b1;
        end else begin
          uv_cnt_reg <= uv_cnt_reg + 3'h1;
        end
      end
    end
  end

  // Non-watchdog conditions still present
  assign cond_present = thermal_shutdown_stage_two || main_regulator_output_short ||
    (main_regulator_output_ov && ovrst_reg) || uv_trip_reg;
  assign cond_act = cond_present;
  // Config 2 first failure does not flag
  assign set_fail = cond_act || (wd_act && !(HW_CONFIG == 2'h1 && !wd_first_reg));

  // Failure flag, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fail_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (set_fail) begin
        fail_flag_reg <= 1'b1;
      end else if (wr_en && paddr == fol_pkg::ADDR_STATUS &&
                   pwdata[fol_pkg::STAT_FAIL_BIT]) begin
        fail_flag_reg <= 1'b0;
      end
    end
  end

  // Watchdog fault flag
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wd_fault_reg <= 1'b0;
    end else if (clk_en) begin
      if (wd_act) begin
        wd_fault_reg <= 1'b1;
      end else if (wd_trig_ok || dev_mode == fol_pkg::FOL_MD_SLEEP || cond_act ||
                   (dev_mode == fol_pkg::FOL_MD_STOP && wd_off_stop)) begin
        wd_fault_reg <= 1'b0;
      end
    end
  end

  // Activation held until conditions and flags clear
  assign active_next = cond_act || wd_act || (active_reg && (cond_present ||
    fail_flag_reg || wd_fault_reg));
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      active_reg <= 1'b0;
      fsafe_req <= 1'b0;
    end else if (clk_en) begin
      active_reg <= active_next;
      fsafe_req <= cond_act || (wd_act && HW_CONFIG != 2'h1);
    end
  end

  // Failure, forced test or fail-safe mode activation
  logic fail_out_force_on;
  logic fail_out_force_on_prev_reg;
  assign fail_out_force_on = active_reg || force_reg || dev_mode == fol_pkg::FOL_MD_FSAFE;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fail_out_force_on_prev_reg <= 1'b0;
    end else if (clk_en) begin
      fail_out_force_on_prev_reg <= fail_out_force_on;
    end
  end

  fol_timebase #(
    .BLINK_HALF(BLINK_HALF),
    .PWM_PERIOD(PWM_PERIOD)
  ) u_timebase (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .clk_en(clk_en),
    .restart(fail_out_force_on && !fail_out_force_on_prev_reg),
    .duty_sel(duty_reg),
    .blink_on(blink_on),
    .dim_on(dim_on)
  );

  // Pin drivers; low-side pulls low, high-side drives high
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fail_static_reg <= 1'b0;
      pin2_drive_reg <= 1'b0;
      pin3_drive_reg <= 1'b0;
      pin2_hi_reg <= 1'b0;
      pin3_hi_reg <= 1'b0;
    end else if (clk_en) begin
      fail_static_reg <= fail_out_force_on && fail_out_force_on_prev_reg;
      pin2_hi_reg <= fn_is(fn2_reg, fol_pkg::FOL_FN_HS);
      pin3_hi_reg <= fn_is(fn3_reg, fol_pkg::FOL_FN_HS);
      case (fn2_reg)
        fol_pkg::FOL_FN_FAIL: pin2_drive_reg <= fail_out_force_on && fail_out_force_on_prev_reg && blink_on;
        fol_pkg::FOL_FN_LS, fol_pkg::FOL_FN_HS: pin2_drive_reg <= sw_on_reg[0] &&
          (dev_mode == fol_pkg::FOL_MD_NORMAL || dev_mode == fol_pkg::FOL_MD_STOP);
        default: pin2_drive_reg <= 1'b0;
      endcase
      case (fn3_reg)
        fol_pkg::FOL_FN_FAIL: pin3_drive_reg <= fail_out_force_on && fail_out_force_on_prev_reg && dim_on;
        fol_pkg::FOL_FN_LS, fol_pkg::FOL_FN_HS: pin3_drive_reg <= sw_on_reg[1] &&
          (dev_mode == fol_pkg::FOL_MD_NORMAL || dev_mode == fol_pkg::FOL_MD_STOP);
        default: pin3_drive_reg <= 1'b0;
      endcase
    end
  end
  assign fail_static_out_o = 1'b0;
  assign fail_static_out_oe = fail_static_reg;
  assign alt_pin_two_o = pin2_hi_reg;
  assign alt_pin_two_oe = pin2_drive_reg;
  assign fail_dim_test_pin_o = pin3_hi_reg;
  assign fail_dim_test_pin_oe = pin3_drive_reg;

  // Wake edge capture and level report
  assign pin_lvl = {fail_dim_test_pin_i, alt_pin_two_i};
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_prev_reg <= 2'h3; // Idle pulled-up level, no false edge after reset
      wake_stat_reg <= 2'h0;
      level_reg <= 2'h0;
    end else if (clk_en) begin
      pin_prev_reg <= pin_lvl;
      for (int i = 0; i < 2; i++) begin
        if (fn_is(i == 0 ? fn2_reg : fn3_reg, fol_pkg::FOL_FN_WAKE) &&
            dev_mode != fol_pkg::FOL_MD_FSAFE && pin_lvl[i] != pin_prev_reg[i]) begin
          wake_stat_reg[i] <= 1'b1;
        end else if (wr_en && paddr == fol_pkg::ADDR_WAKE && pwdata[i]) begin
          wake_stat_reg[i] <= 1'b0;
        end
        if (!fn_is(i == 0 ? fn2_reg : fn3_reg, fol_pkg::FOL_FN_FAIL) &&
            (dev_mode == fol_pkg::FOL_MD_NORMAL || dev_mode == fol_pkg::FOL_MD_STOP)) begin
          level_reg[i] <= pin_lvl[i];
        end
      end
    end
  end

  // Read data mux
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0;
    end else if (rd_en && clk_en) begin
      case (paddr)
        fol_pkg::ADDR_CTRL: prdata <= {28'h0, duty_reg, ovrst_reg, force_reg};
        fol_pkg::ADDR_ALT: prdata <= {26'h0, sw_on_reg, fn3_reg, fn2_reg};
        fol_pkg::ADDR_STATUS: prdata <= {28'h0, dev_mode == fol_pkg::FOL_MD_FSAFE,
          fail_out_force_on, wd_fault_reg, fail_flag_reg};
        fol_pkg::ADDR_WAKE: prdata <= {30'h0, wake_stat_reg};
        fol_pkg::ADDR_LEVEL: prdata <= {30'h0, level_reg};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Assertions
  AST_STATIC_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && fail_out_force_on && fail_out_force_on_prev_reg |=> fail_static_out_oe)
    else $error("static output not active");
  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && set_fail |=> fail_flag_reg) else $error("failure flag not set");
  AST_FORCE_ON: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    force_reg && clk_en ##1 force_reg && clk_en |=> fail_static_out_oe)
    else $error("force not active");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && active_reg && fail_flag_reg |=> active_reg) else $error("released early");
  AST_WD_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && active_reg && wd_fault_reg |=> active_reg) else $error("wd hold lost");
  AST_SLEEP_CLR: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && !wd_act && dev_mode == fol_pkg::FOL_MD_SLEEP |=> !wd_fault_reg)
    else $error("wd fault not cleared");
  AST_SW_SLEEP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && (fn3_reg == fol_pkg::FOL_FN_LS || fn3_reg == fol_pkg::FOL_FN_HS) &&
    dev_mode == fol_pkg::FOL_MD_SLEEP |=> !fail_dim_test_pin_oe)
    else $error("switch not off in sleep");
  AST_NO_DRIVE_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && fn2_reg == fol_pkg::FOL_FN_WAKE |=> !alt_pin_two_oe)
    else $error("wake pin driven");
  AST_COND_ACT: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    clk_en && thermal_shutdown_stage_two |=> active_reg) else $error("thermal not active");
endmodule : fol_top

//--- dv/fol_lamp_model.sv
`timescale 1ns/1ps
// Lamps and loads on the three fail pins, static pin pulled up when released
module fol_lamp_model (
  input wire logic fail_static_out_o, // Static pin drive level
  input wire logic fail_static_out_oe, // Static pin drive enable
  input wire logic alt_pin_two_o, // Second pin drive level
  input wire logic alt_pin_two_oe, // Second pin drive enable
  input wire logic fail_dim_test_pin_o, // Third pin drive level
  input wire logic fail_dim_test_pin_oe, // Third pin drive enable
  input wire logic ext_two, // Outside level on second pin
  input wire logic ext_three, // Outside level on third pin
  output logic static_lvl, // Static pin wire level
  output logic two_lvl, // Second pin wire level
  output logic three_lvl // Third pin wire level
);
  // Open-drain wires: driven level while enabled, else pulled high on the static pin and outside level on the other two
  assign static_lvl = fail_static_out_oe ? fail_static_out_o : 1'b1;
  assign two_lvl = alt_pin_two_oe ? alt_pin_two_o : ext_two;
  assign three_lvl = fail_dim_test_pin_oe ? fail_dim_test_pin_o : ext_three;
endmodule : fol_lamp_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int BH = 40;
  localparam int PP = 40;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, fsafe_req, err, fs, b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [1:0] dev_mode, sel;
  logic [3:0] evt; // Watchdog fail, watchdog ok, undervoltage, back in range
  logic [2:0] lvl; // Overvoltage, short, thermal
  logic wd_off_stop, ext2, ext3, st_o, st_oe, p2_o, p2_oe, p3_o, p3_oe, st_lvl, bl_lvl, dm_lvl;
  int bad_count, checked, cyc, lo_st, lo_bl, lo_dm;
  // Device under test, third hardware configuration
  fol_top #(.BLINK_HALF(BH), .PWM_PERIOD(PP), .HW_CONFIG(2'h2)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_mode(dev_mode), .watchdog_fault_flag_evt(evt[3]), .wd_trig_ok(evt[2]),
    .wd_off_stop(wd_off_stop), .thermal_shutdown_stage_two(lvl[0]),
    .main_regulator_output_short(lvl[1]), .main_regulator_output_ov(lvl[2]),
    .main_regulator_output_uv_evt(evt[1]), .main_regulator_output_uv_ok(evt[0]),
    .fsafe_req(fsafe_req), .fail_static_out_o(st_o), .fail_static_out_oe(st_oe),
    .alt_pin_two_i(bl_lvl), .alt_pin_two_o(p2_o), .alt_pin_two_oe(p2_oe),
    .fail_dim_test_pin_i(dm_lvl), .fail_dim_test_pin_o(p3_o), .fail_dim_test_pin_oe(p3_oe));
  // Loads on the pins
  fol_lamp_model lamps (
    .fail_static_out_o(st_o), .fail_static_out_oe(st_oe), .alt_pin_two_o(p2_o),
    .alt_pin_two_oe(p2_oe), .fail_dim_test_pin_o(p3_o), .fail_dim_test_pin_oe(p3_oe),
    .ext_two(ext2), .ext_three(ext3), .static_lvl(st_lvl), .two_lvl(bl_lvl),
    .three_lvl(dm_lvl));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // Active cycles of PWM: period over 5, 10, 20, 40
  function automatic int duty_cyc(input logic [1:0] s);
    return PP / (5 << s);
  endfunction : duty_cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // Read data stands at the access edge
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data & m, exp);
    chk(err, a > fol_pkg::ADDR_LEVEL);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk_sys);
    evt <= 4'h8 >> k;
    @(posedge clk_sys);
    evt <= 4'h0;
  endtask : pulse
  task automatic setlvl(input logic [2:0] v);
    @(posedge clk_sys);
    lvl <= v;
  endtask : setlvl
  task automatic setmode(input logic [1:0] m);
    @(posedge clk_sys);
    dev_mode <= m;
    repeat (4) @(negedge clk_sys);
  endtask : setmode
  task automatic settle(input logic exp);
    repeat (4) @(negedge clk_sys);
    chk(st_oe, exp);
  endtask : settle
  // Waits for activation, then all three must be on together
  task automatic act_wait();
    int n;
    n = 0;
    fs = 1'b0;
    while (st_oe !== 1'b1 && n < 8) begin
      @(negedge clk_sys);
      fs = fs | fsafe_req;
      n++;
    end
    chk({st_oe, p2_oe, p3_oe}, 3'h7);
  endtask : act_wait
  task automatic meas(input int n);
    lo_st = 0;
    lo_bl = 0;
    lo_dm = 0;
    repeat (4) @(negedge clk_sys);
    repeat (n) begin
      @(negedge clk_sys);
      lo_st += !st_lvl;
      lo_bl += !bl_lvl;
      lo_dm += !dm_lvl;
    end
  endtask : meas
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, evt, lvl, wd_off_stop} = '0;
    {dev_mode, ext2, ext3, bad_count, checked, cyc} = {fol_pkg::FOL_MD_NORMAL, 2'h3, 96'h0};
    void'($urandom(32'h187aa503));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values and an unmapped place
    rd(fol_pkg::ADDR_CTRL, 32'hf, 32'h0);
    rd(fol_pkg::ADDR_ALT, 32'h3f, 32'h0);
    rd(fol_pkg::ADDR_STATUS, 32'h3, 32'h0);
    rd(8'h14, 32'hffffffff, 32'h0);
    chk(st_oe, 1'b0);
    // Forced activation and duty sweep through all four from a random start
    wr(fol_pkg::ADDR_CTRL, 32'h1);
    act_wait();
    meas(2 * BH);
    chk(lo_st, 2 * BH);
    chk(lo_bl, BH);
    sel = 2'($urandom);
    for (int s = 0; s < 4; s++) begin
      sel = sel + 2'h1;
      wr(fol_pkg::ADDR_CTRL, {28'h0, sel, 2'h1});
      meas(PP);
      chk(lo_dm, duty_cyc(sel));
    end
    wr(fol_pkg::ADDR_CTRL, 32'h0);
    wr(fol_pkg::ADDR_STATUS, 32'h1);
    settle(1'b0);
    // Level causes: thermal, short, enabled overvoltage
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        setlvl(3'h4);
        settle(1'b0);
        wr(fol_pkg::ADDR_CTRL, 32'h2);
      end
      setlvl(3'h1 << k);
      act_wait();
      chk(fs, 1'b1);
      rd(fol_pkg::ADDR_STATUS, 32'h1, 32'h1);
      wr(fol_pkg::ADDR_STATUS, 32'h1);
      settle(1'b1);
      setlvl(3'h0);
      settle(1'b1);
      wr(fol_pkg::ADDR_STATUS, 32'h1);
      settle(1'b0);
    end
    wr(fol_pkg::ADDR_CTRL, 32'h0);
    // Undervoltage run broken after three, then four in a row
    repeat (3) pulse(2);
    pulse(3);
    repeat (3) pulse(2);
    settle(1'b0);
    pulse(2);
    act_wait();
    pulse(3);
    wr(fol_pkg::ADDR_STATUS, 32'h1);
    settle(1'b0);
    // Watchdog: second failure activates, fault flag gates release
    pulse(0);
    settle(1'b0);
    pulse(0);
    act_wait();
    rd(fol_pkg::ADDR_STATUS, 32'h3, 32'h3);
    wr(fol_pkg::ADDR_STATUS, 32'h1);
    settle(1'b1);
    pulse(1);
    wr(fol_pkg::ADDR_STATUS, 32'h1);
    settle(1'b0);
    // Fault flag cleared by sleep, and by stop with watchdog off
    for (int m = 0; m < 2; m++) begin
      pulse(0);
      pulse(0);
      settle(1'b1);
      wd_off_stop <= m[0];
      setmode(m[0] ? fol_pkg::FOL_MD_STOP : fol_pkg::FOL_MD_SLEEP);
      chk(st_oe, 1'b1);
      rd(fol_pkg::ADDR_STATUS, 32'h2, 32'h0);
      wd_off_stop <= 1'b0;
      setmode(fol_pkg::FOL_MD_NORMAL);
      wr(fol_pkg::ADDR_STATUS, 32'h1);
      settle(1'b0);
    end
    // Second pin wake input, third pin high-side switch on
    wr(fol_pkg::ADDR_ALT, 32'h3d);
    settle(1'b0);
    chk({p2_oe, p3_oe, p3_o}, 3'h3);
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 1'b0 : 1'($urandom);
      ext2 <= b;
      rd(fol_pkg::ADDR_LEVEL, 32'h3, {30'h0, 1'b1, b});
    end
    rd(fol_pkg::ADDR_WAKE, 32'h1, 32'h1);
    wr(fol_pkg::ADDR_WAKE, 32'h3);
    rd(fol_pkg::ADDR_WAKE, 32'h1, 32'h0);
    setmode(fol_pkg::FOL_MD_STOP);
    chk({p3_oe, p3_o}, 2'h3);
    setmode(fol_pkg::FOL_MD_SLEEP);
    chk({st_oe, p3_oe}, 2'h0);
    setmode(fol_pkg::FOL_MD_FSAFE);
    chk({st_oe, p2_oe, p3_oe}, 3'h4);
    setmode(fol_pkg::FOL_MD_NORMAL);
    wr(fol_pkg::ADDR_STATUS, 32'h1);
    // Third pin low-side switch on pulls its level low
    wr(fol_pkg::ADDR_ALT, 32'h28);
    settle(1'b0);
    chk({p3_oe, p3_o}, 2'h2);
    rd(fol_pkg::ADDR_LEVEL, 32'h2, 32'h0);
    wrap_up();
  end
endmodule : testbench
